// *** hdl/fast_fork_instruction_decoder.sv ***
/*
 * fast first-level fork decoder: keeps its own copy of the instruction
 * register, forms a fork address from instruction classes, merges it into
 * the microword next-address field and holds the microprogram address.
 * assumes the load strobe, microword fields and status inputs come from
 * logic on the same machine clock.
 */
// Behaviour
// - fork address valid one cycle after load
// - halt group sets bit 3, copies opcode
// - bits ORed, merged by bit-clear into field
// - low group excludes all other fork bits
// - low group passes destination mode bits
// - single-operand patterns raise their class signal
// - mul, div, ash, ashc enable low group
// - binary with source mode zero uses low group
// - jmp, jsr, swab reuse destination calculation
// - branch with bus request sets bit 3
// - opcodes 0..7 map to 010..017, 017 traps
// - extended class with reg7 or request goes 030
// - binary both modes zero sets bit 3 separately
// - decoder reads its own instruction copy
// - fork enable loads fork address instead
`timescale 1ns/10ps
`default_nettype none

module fast_fork_instruction_decoder
    import fork_pkg::*;
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               resetn,
    // instruction register load
    input  wire logic               loadInstr,          // copy strobe, same as main copy
    input  wire logic [INSTR_W-1:0] instrIn,            // instruction word from memory
    // status
    input  wire logic               pendingBusService,  // bus request waiting
    input  wire logic               destRegisterSeven,  // destination register is 7
    // microword
    input  wire logic               forkEnable,         // fork enable bit of this fork
    input  wire logic [ADDR_W-1:0]  nextMicroaddressField, // next-address field
    // results
    output logic      [ADDR_W-1:0]  forkAddress,        // combinational fork address
    output logic      [ADDR_W-1:0]  microAddress,       // microprogram address register
    output logic      [INSTR_W-1:0] instrCopy,          // dedicated copy, registered
    output logic                    undefinedTrap,      // registered: entered 017 by fork
    output logic      [ADDR_W-1:0]  trapVector          // vector for undefined opcode
);

    // ------------------------------------------------------------------
    // dedicated instruction copy
    // ------------------------------------------------------------------
    fork_class_if cls ();                    // copy and classes
    logic [INSTR_W-1:0] fastDecodeInstrCopy_q;  // copy register

    // loads together with the main copy; only this fork reads it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fastDecodeInstrCopy_q <= INSTR_RESET;
        end else if (loadInstr) begin
            fastDecodeInstrCopy_q <= instrIn;
        end
    end

    assign cls.fastDecodeInstrCopy = fastDecodeInstrCopy_q;
    assign instrCopy               = fastDecodeInstrCopy_q;

    // class recognition kept one level deep for speed
    fork_class_decode classDecode (
        .cls (cls.decoder)
    );

    // ------------------------------------------------------------------
    // per-class fork signals
    // ------------------------------------------------------------------
    logic [2:0] destMode;          // destination mode bits of the copy
    logic [2:0] opLow;             // low three opcode bits
    logic       escapeBusy;        // reg7 or bus request
    logic       bothModesZero;     // binary with both modes zero
    logic       extendedClass;     // instructions that may escape to 030
    logic       escapeFork;        // go to 030
    logic       lowGroupEnable;    // destination-mode group enable
    logic [2:0] forkLowGroup;      // low address group output
    logic       forkBit3Signal;    // halt, branch and escape bit 3
    logic       forkAltBit3Signal; // binary both-modes-zero bit 3
    logic       branchBusBit3;     // branch with request

    assign destMode      = fastDecodeInstrCopy_q[DMODE_LSB+:3];
    assign opLow         = fastDecodeInstrCopy_q[2:0];
    assign escapeBusy    = destRegisterSeven || pendingBusService;
    assign bothModesZero = cls.twoOperandClass && cls.sourceModeZero && cls.destinationModeZero;

    // extended class: single operand, binary or jmp/jsr/swab with destination mode zero
    assign extendedClass = (cls.singleOperandClass || cls.twoOperandClass || cls.jumpClass)
                         && cls.destinationModeZero;

    // escape to 030, binary both-modes-zero handled separately
    assign escapeFork = extendedClass && !bothModesZero && escapeBusy;

    // low group: single operand, reg/mem, binary source mode 0, jmp/jsr/swab
    assign lowGroupEnable = (cls.singleOperandClass
                          || cls.regMemClass
                          || (cls.twoOperandClass && cls.sourceModeZero)
                          || cls.jumpClass)
                          && !escapeFork;

    // identical enables, each gate passes its own mode bit
    assign forkLowGroup = {3{lowGroupEnable}} & destMode;

    // branch during a bus request sets only bit 3 and lands on 010
    assign branchBusBit3 = cls.branchClass && pendingBusService;

    // bit 3 sources of the main signal
    assign forkBit3Signal = cls.haltGroup
                         || branchBusBit3
                         || escapeFork;

    // separate bit 3 for binary with both modes zero
    assign forkAltBit3Signal = bothModesZero && escapeBusy;

    // ------------------------------------------------------------------
    // address assembly: every bit is the OR of its sources
    // ------------------------------------------------------------------
    always_comb begin
        forkAddress = '0;
        // low bits: destination mode group or halt group opcode
        forkAddress[2:0] = forkLowGroup | ({3{cls.haltGroup}} & opLow);
        // bit 3
        forkAddress[BIT3_POS] = forkBit3Signal || forkAltBit3Signal;
        // bit 4 only for the escape address
        forkAddress[4] = escapeFork;
    end

    // ------------------------------------------------------------------
    // merge with the microword and the address register
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] microAddr_d;  // next microprogram address
    logic [ADDR_W-1:0] microAddr_q;  // microprogram address register

    // bit-clear: enabled fork clears the field, then its own bits stand
    assign microAddr_d = (nextMicroaddressField & ~{ADDR_W{forkEnable}})
                       | (forkAddress & {ADDR_W{forkEnable}});

    // captured on the next machine clock edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            microAddr_q <= UADDR_RESET;
        end else begin
            microAddr_q <= microAddr_d;
        end
    end

    assign microAddress = microAddr_q;

    // ------------------------------------------------------------------
    // undefined opcode 000007
    // ------------------------------------------------------------------
    logic undefTrap_q;  // set when the fork sends the undefined opcode to 017

    // flags the trap cycle so the trap sequence can fetch the vector
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            undefTrap_q <= 1'b0;
        end else begin
            undefTrap_q <= forkEnable && cls.haltGroup && (opLow == 3'h7);
        end
    end

    assign undefinedTrap = undefTrap_q;
    assign trapVector    = TRAP_VECTOR;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    haltGroup_a: assert property (@(posedge clock) disable iff (!resetn)
        (fastDecodeInstrCopy_q[15:3] == 13'h0000) |-> (forkAddress == {5'h01, opLow}))
        else $error("halt group address wrong");

    undefAddr_a: assert property (@(posedge clock) disable iff (!resetn)
        (forkEnable && fastDecodeInstrCopy_q == 16'h0007) |=> (microAddr_q == UNDEF_ADDR && undefTrap_q))
        else $error("undefined opcode not sent to 017 with trap");

    lowGroupQuiet_a: assert property (@(posedge clock) disable iff (!resetn)
        (forkLowGroup != 3'h0) |-> (forkAddress[7:3] == 5'h00))
        else $error("other fork bits with low group");

    singleOperand_a: assert property (@(posedge clock) disable iff (!resetn)
        (!fastDecodeInstrCopy_q[14] && !fastDecodeInstrCopy_q[13] && !fastDecodeInstrCopy_q[12]
         && fastDecodeInstrCopy_q[11:9] == 3'h5 && !cls.destinationModeZero)
        |-> (forkAddress == {5'h00, destMode}))
        else $error("single operand not on low group");

    branchBus_a: assert property (@(posedge clock) disable iff (!resetn)
        (cls.branchClass && pendingBusService) |-> forkAddress[BIT3_POS])
        else $error("branch with request lacks bit 3");

    escape_a: assert property (@(posedge clock) disable iff (!resetn)
        (cls.singleOperandClass && cls.destinationModeZero && destRegisterSeven) |-> (forkAddress == ESCAPE_ADDR))
        else $error("escape address not 030");

    altBit3_a: assert property (@(posedge clock) disable iff (!resetn)
        (bothModesZero && pendingBusService) |-> (forkAddress == 8'h08))
        else $error("binary both modes zero lacks bit 3");

    copyLoad_a: assert property (@(posedge clock) disable iff (!resetn)
        loadInstr |=> (fastDecodeInstrCopy_q == $past(instrIn)))
        else $error("instruction copy not loaded");

    forkLoad_a: assert property (@(posedge clock) disable iff (!resetn)
        forkEnable |=> (microAddr_q == $past(forkAddress)))
        else $error("fork address not loaded");

    fieldLoad_a: assert property (@(posedge clock) disable iff (!resetn)
        !forkEnable |=> (microAddr_q == $past(nextMicroaddressField)))
        else $error("field not loaded without fork");

    loadToFork_a: assert property (@(posedge clock) disable iff (!resetn)
        (loadInstr && instrIn == 16'h0005) ##1 forkEnable |=> (microAddr_q == 8'h0D))
        else $error("fork not ready one cycle after load");

endmodule : fast_fork_instruction_decoder

`default_nettype wire

// *** hdl/fork_class_decode.sv ***
/*
 * shallow instruction class recognition for the fast fork.
 * assumes the instruction copy on the interface is a register output.
 */
`timescale 1ns/10ps
`default_nettype none

module fork_class_decode
    import fork_pkg::*;
(
    // class signals
    fork_class_if.decoder cls
);

    // ------------------------------------------------------------------
    // field views
    // ------------------------------------------------------------------
    logic [INSTR_W-1:0] ir;   // local name for the copy
    logic [2:0]         grp;  // instr[14:12]
    logic [2:0]         sub;  // instr[11:9]

    assign ir  = cls.fastDecodeInstrCopy;
    assign grp = ir[14:12];
    assign sub = ir[11:9];

    // ------------------------------------------------------------------
    // class recognition, one gate level each
    // ------------------------------------------------------------------
    // halt .. rtt group: all but the low three bits zero
    assign cls.haltGroup = (ir[INSTR_W-1:HALT_LSB] == '0);

    // single operand x05xDD, x06xDD, plus xor
    assign cls.singleOperandClass = ((grp == GRP_SINGLE) && (sub == SUB_SINGLE5 || sub == SUB_SINGLE6))
                                  || (!ir[15] && grp == GRP_REGMEM && sub == SUB_XOR);

    // mul, div, ash, ashc: 070..073
    assign cls.regMemClass = !ir[15] && (grp == GRP_REGMEM) && !ir[11];

    // binary: groups 1..6, either width
    assign cls.twoOperandClass = (grp != GRP_SINGLE) && (grp != GRP_REGMEM);

    // jmp, jsr, swab share the single-operand address calculation
    assign cls.jumpClass = (ir[15:6] == OPC_JMP) || (ir[15:6] == OPC_SWAB) || (ir[15:9] == OPC_JSR);

    // branches: 0004xx..0034xx and 1000xx..1034xx
    assign cls.branchClass = (ir[14:11] == 4'h0) && (ir[15] || (ir[10:8] != 3'h0));

    // mode fields
    assign cls.sourceModeZero      = (ir[SMODE_LSB+:3] == 3'h0);
    assign cls.destinationModeZero = (ir[DMODE_LSB+:3] == 3'h0);

endmodule : fork_class_decode

`default_nettype wire

// *** hdl/fork_class_if.sv ***
/*
 * carries the dedicated instruction copy and the decoded class signals
 * between the class decoder and the fork address assembly.
 * assumes both ends run on the same machine clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface fork_class_if;
    import fork_pkg::*;
    logic [INSTR_W-1:0] fastDecodeInstrCopy;  // dedicated instruction copy
    logic               haltGroup;            // opcodes 000000..000007
    logic               singleOperandClass;   // x05xDD, x06xDD, xor
    logic               regMemClass;          // mul, div, ash, ashc
    logic               twoOperandClass;      // binary instructions
    logic               jumpClass;            // jmp, jsr, swab
    logic               branchClass;          // branch instructions, BR included
    logic               sourceModeZero;       // source mode field is 0
    logic               destinationModeZero;  // destination mode field is 0

    // class decoder drives the classes from the copy
    modport decoder (input fastDecodeInstrCopy, output haltGroup, singleOperandClass,
                     regMemClass, twoOperandClass, jumpClass, branchClass,
                     sourceModeZero, destinationModeZero);
    // assembly drives the copy and reads the classes
    modport assembler (output fastDecodeInstrCopy, input haltGroup, singleOperandClass,
                       regMemClass, twoOperandClass, jumpClass, branchClass,
                       sourceModeZero, destinationModeZero);
endinterface : fork_class_if

`default_nettype wire

// *** hdl/fork_pkg.sv ***
/*
 * constants for the fast first-level fork decoder: instruction field
 * positions, opcode patterns, fixed fork addresses and reset values.
 * assumes a 16-bit instruction word and an 8-bit microprogram address.
 */
`default_nettype none

package fork_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int INSTR_W = 16;   // instruction word width
    localparam int ADDR_W  = 8;    // microprogram address width

    // ------------------------------------------------------------------
    // instruction field positions
    // ------------------------------------------------------------------
    localparam int DREG_LSB  = 0;  // destination register field
    localparam int DMODE_LSB = 3;  // destination mode field
    localparam int SMODE_LSB = 9;  // source mode field
    localparam int HALT_LSB  = 3;  // bits above this are zero in the halt group

    // ------------------------------------------------------------------
    // opcode patterns (instr[14:12] group, instr[11:9] sub-field)
    // ------------------------------------------------------------------
    localparam logic [2:0]  GRP_SINGLE  = 3'h0;   // single-operand group
    localparam logic [2:0]  GRP_REGMEM  = 3'h7;   // register-and-memory group
    localparam logic [2:0]  SUB_SINGLE5 = 3'h5;   // x05xDD
    localparam logic [2:0]  SUB_SINGLE6 = 3'h6;   // x06xDD
    localparam logic [2:0]  SUB_XOR     = 3'h4;   // 074RDD
    localparam logic [6:0]  OPC_JSR     = 7'h04;  // 004RDD, instr[15:9]
    localparam logic [9:0]  OPC_JMP     = 10'h001; // 0001DD, instr[15:6]
    localparam logic [9:0]  OPC_SWAB    = 10'h003; // 0003DD, instr[15:6]

    // ------------------------------------------------------------------
    // fixed fork addresses and bit positions
    // ------------------------------------------------------------------
    localparam int             BIT3_POS     = 3;     // shared fork address bit 3
    localparam logic [7:0]     ESCAPE_ADDR  = 8'h18; // octal 030
    localparam logic [7:0]     UNDEF_ADDR   = 8'h0F; // octal 017
    localparam logic [7:0]     TRAP_VECTOR  = 8'h04; // vector for undefined opcode
    localparam logic [15:0]    INSTR_RESET  = 16'h0000;
    localparam logic [7:0]     UADDR_RESET  = 8'h00;

endpackage : fork_pkg

`default_nettype wire

// *** test/sequencer_model.sv ***
/*
 * behavioural microprogram sequencer and instruction register logic that
 * feeds the fast fork decoder: load strobe, instruction word, fork enable
 * and next-address field, plus the main instruction copy.
 * assumes the bench calls step from its main sequence; step outputs change only
 * just after a falling clock edge, mainCopy just after a rising one.
 */
`timescale 1ns/10ps
`default_nettype none

module sequencer_model
    import fork_pkg::*;
(
    // clock
    input  wire logic               clock,
    // instruction register load
    output logic                    loadInstr,             // load strobe for both copies
    output logic      [INSTR_W-1:0] instrIn,               // instruction word from memory
    // microword
    output logic                    forkEnable,            // fork enable bit of this fork
    output logic      [ADDR_W-1:0]  nextMicroaddressField, // next-address field
    // main copy
    output logic      [INSTR_W-1:0] mainCopy               // main instruction register
);

    // ------------------------------------------------------------------
    // start values
    // ------------------------------------------------------------------
    initial begin
        loadInstr             = 1'b0;
        instrIn               = 16'h0000;
        forkEnable            = 1'b0;
        nextMicroaddressField = 8'h00;
        mainCopy              = 16'h0000;
    end

    // main copy loads on the same strobe and edge as the fast copy
    always @(posedge clock) begin
        if (loadInstr) begin
            mainCopy <= instrIn;
        end
    end

    // one microword per cycle; an idle data bus shows the inverse of its last word
    task automatic step(input logic load, input logic [INSTR_W-1:0] word,
                        input logic en, input logic [ADDR_W-1:0] field);
        @(negedge clock);
        loadInstr             = load;
        instrIn               = load ? word : ~instrIn;
        forkEnable            = en;
        nextMicroaddressField = field;
    endtask : step

endmodule : sequencer_model

`default_nettype wire

// *** test/test_fast_fork_instruction_decoder.sv ***
/*
 * self-checking bench for the fast fork decoder: loads instructions of
 * every class, sweeps bus request and register-7 status, and checks the
 * fork address, the microprogram address, the trap flag and reset values.
 * assumes the sequencer model in sequencer_model.sv and fork_pkg.
 */
`timescale 1ns/10ps
`default_nettype none

module test_fast_fork_instruction_decoder;
    import fork_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic               clock;             // machine clock
    logic               resetn;            // async reset, active low
    logic               loadInstr;         // from the sequencer
    logic [INSTR_W-1:0] instrIn;           // from the sequencer
    logic               pendingBusService; // bus request status
    logic               destRegisterSeven; // register 7 status
    logic               forkEnable;        // from the sequencer
    logic [ADDR_W-1:0]  nextField;         // from the sequencer
    logic [ADDR_W-1:0]  forkAddress;       // combinational fork address
    logic [ADDR_W-1:0]  microAddress;      // microprogram address register
    logic [INSTR_W-1:0] instrCopy;         // fast copy
    logic [INSTR_W-1:0] mainCopy;          // main copy in the model
    logic               undefinedTrap;     // trap flag
    logic [ADDR_W-1:0]  trapVector;        // trap vector
    int                 fails;             // mismatch count
    int                 checks;            // comparison count
    // several words of each class
    logic [INSTR_W-1:0] vecs [19] = '{16'h0000, 16'h0003, 16'h0005, 16'h0007,
        16'h0A1F, 16'h0A00, 16'h8C57, 16'h788D,
        16'h710A, 16'h7280,
        16'h1052, 16'h1042, 16'h6242,
        16'h004B, 16'h00C0, 16'h09DF,
        16'h0100, 16'h800A, 16'h0087};

    // ------------------------------------------------------------------
    // clock, design and sequencer
    // ------------------------------------------------------------------
    initial clock = 1'b0;
    always #5 clock = ~clock;

    fast_fork_instruction_decoder uut (
        .clock(clock), .resetn(resetn), .loadInstr(loadInstr), .instrIn(instrIn),
        .pendingBusService(pendingBusService), .destRegisterSeven(destRegisterSeven),
        .forkEnable(forkEnable), .nextMicroaddressField(nextField), .forkAddress(forkAddress),
        .microAddress(microAddress), .instrCopy(instrCopy), .undefinedTrap(undefinedTrap),
        .trapVector(trapVector));

    sequencer_model seq (
        .clock(clock), .loadInstr(loadInstr), .instrIn(instrIn), .forkEnable(forkEnable),
        .nextMicroaddressField(nextField), .mainCopy(mainCopy));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // expected fork address worked out from the class map
    function automatic logic [7:0] expFork(input logic [15:0] w, input logic busPend, input logic regSeven);
        logic       sgl, rm, dual, jj, br, st, bsm0;
        logic [7:0] a;
        sgl  = (w[14:12] == 3'h0 && (w[11:9] == 3'h5 || w[11:9] == 3'h6)) || w[15:9] == 7'h3C;
        rm   = w[15:12] == 4'h7 && !w[11];
        dual = w[14:12] != 3'h0 && w[14:12] != 3'h7;
        jj   = w[15:6] == 10'h001 || w[15:6] == 10'h003 || w[15:9] == 7'h04;
        br   = w[14:11] == 4'h0 && (w[15] || w[10:8] != 3'h0);
        st   = busPend | regSeven;
        bsm0 = dual && w[11:9] == 3'h0;
        a    = 8'h00;
        if (w[15:3] == 13'h0000) a = {5'h01, w[2:0]};
        if (sgl || rm || jj || bsm0) a = a | {5'h00, w[5:3]};
        if ((sgl || dual || jj) && w[5:3] == 3'h0 && !bsm0 && st) a = a | 8'h18;
        if (bsm0 && w[5:3] == 3'h0 && st) a = a | 8'h08;
        if (br && busPend) a = a | 8'h08;
        return a;
    endfunction : expFork

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] expected);
        checks++;
        if (seen !== expected) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expected);
        end
    endtask : check

    // load one word, then fork it under every status pair, then one plain step
    task automatic runVec(input logic [15:0] w);
        logic [7:0] e;
        seq.step(1'b1, w, 1'b0, 8'h5A);
        for (int k = 0; k < 4; k++) begin
            seq.step(1'b0, 16'h0000, 1'b1, 8'hC3);
            pendingBusService = k[0];
            destRegisterSeven = k[1];
            e = expFork(w, k[0], k[1]);
            #1;
            check(16'(forkAddress), 16'(e));
            check(instrCopy, mainCopy);
            @(posedge clock);
            #1;
            check(16'(microAddress), 16'(e));
            check(16'(undefinedTrap), 16'(w == 16'h0007));
        end
        seq.step(1'b0, 16'h0000, 1'b0, 8'h3C);
        @(posedge clock);
        #1;
        check(16'(microAddress), 16'h003C);
        check(16'(undefinedTrap), 16'h0000);
    endtask : runVec

    // verdict and end of run
    task automatic conclude;
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        fails             = 0;
        checks            = 0;
        resetn            = 1'b0;
        pendingBusService = 1'b0;
        destRegisterSeven = 1'b0;
        repeat (12) @(posedge clock);
        @(negedge clock);
        check(16'(forkAddress), 16'h0008);
        check(16'(microAddress), 16'h0000);
        check(16'(trapVector), 16'h0004);
        resetn = 1'b1;
        foreach (vecs[i]) runVec(vecs[i]);
        // reset again with a live instruction in the copy
        seq.step(1'b1, 16'h0A1F, 1'b1, 8'h77);
        seq.step(1'b0, 16'h0000, 1'b1, 8'h77);
        resetn = 1'b0;
        #1;
        check(instrCopy, 16'h0000);
        check(16'(microAddress), 16'h0000);
        check(16'(forkAddress), 16'h0008);
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        runVec(16'h0007);
        conclude();
    end

    initial begin
        #20000;
        fails++;
        conclude();
    end

endmodule : test_fast_fork_instruction_decoder

`default_nettype wire
